// ### inc/cpu_flags_pkg.sv
// Shared constants and types for the flags and ALU execution block
package cpu_flags_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] ADDR_OP = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_DST = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_SRC = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_RESULT = 8'h0C;
    localparam logic [AXI_AW-1:0] ADDR_FLAGS = 8'h10;
    localparam logic [AXI_AW-1:0] ADDR_SP = 8'h14;
    localparam logic [AXI_AW-1:0] ADDR_PC = 8'h18;
    localparam logic [AXI_AW-1:0] ADDR_VECTOR_PC = 8'h1C;
    localparam logic [AXI_AW-1:0] ADDR_EVENT = 8'h20;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h24;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam int FLAG_USER2 = 1;
    localparam int FLAG_USER1 = 0;
    localparam logic [7:0] OPS_FLAG_MASK = 8'hFC;
    localparam int OP_MAP2_BIT = 8;
    localparam int EV_INTERRUPT = 0;
    localparam int EV_ILLEGAL = 1;
    localparam int EV_INTERRUPT_RETURN_OP = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_UNSUPPORTED = 1;
    localparam int ST_BANK_LSB = 8;
    localparam int RES_WRITTEN = 8;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Opcodes handled here
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_SHIFT_R = 8'hC0;
    localparam logic [7:0] OPC_SHIFT_IR = 8'hC1;
    localparam logic [7:0] OPC_BANK_LOAD = 8'h01;
    localparam logic [7:0] OPC_WDOG = 8'h5F;
    localparam logic [7:0] OPC_TRAP = 8'hF2;
    localparam logic [7:0] OPC_SUB_LO = 8'h22;
    localparam logic [7:0] OPC_SUB_HI = 8'h29;
    localparam logic [7:0] OPC_SWAP_R = 8'hF0;
    localparam logic [7:0] OPC_SWAP_IR = 8'hF1;
    localparam logic [7:0] OPC_TCM_LO = 8'h62;
    localparam logic [7:0] OPC_TCM_HI = 8'h69;
    localparam logic [7:0] OPC_TM_LO = 8'h72;
    localparam logic [7:0] OPC_TM_HI = 8'h79;
    localparam logic [7:0] OPC_XOR_LO = 8'hB2;
    localparam logic [7:0] OPC_XOR_HI = 8'hB9;

    // ------------------------------------------------------------
    // Stack sequencer states, Gray coded along push and pop paths except the two-bit step from SEQ_IDLE to SEQ_POP_FLAGS
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_PUSH_PC_HI = 3'h1,
        SEQ_PUSH_PC_LO = 3'h3,
        SEQ_PUSH_FLAGS = 3'h2,
        SEQ_POP_FLAGS = 3'h6,
        SEQ_POP_PC_HI = 3'h7,
        SEQ_POP_PC_LO = 3'h5,
        SEQ_POP_DONE = 3'h4
    } seq_state_t;

    // Result of one ALU operation
    typedef struct packed {
        logic known;
        logic store;
        logic [7:0] res;
        logic [7:0] flags;
    } alu_out_t;

endpackage

// ### src/stack_ram.sv
// Small byte-wide stack memory with registered read data
`timescale 1ns/1ps

module stack_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Access port
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [DW-1:0] mem [2**AW];

    // Array has no reset; stacked contents are only valid once pushed
    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Read data registered, one cycle after the address
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= mem[i_addr];
        end
    end

endmodule

// ### src/cpu_flags_alu.sv
// Flags register, ALU operations and flag stacking behind an AXI4-Lite slave
`timescale 1ns/1ps

// Function
// - flags always show the outcome of the latest flag-setting operation
// - six operation flags; carry, overflow, zero, sign feed jump conditions
// - half-carry and decimal-adjust serve decimal maths only, never jump conditions
// - user bits change only by explicit write or interrupt return, never by arithmetic or jumps
// - user bits are not touched by reset and start undefined
// - interrupt, vector call and illegal trap push the whole flags byte
// - interrupt return reloads flags from the stacked byte
// - logical right shift: zero into bit 7, bit 0 to carry, sign cleared
// - vector call pushes PC then flags, loads PC from vector, flags kept
module cpu_flags_alu
    import cpu_flags_pkg::*;
#(
    parameter int STACK_AW = 8
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [cpu_flags_pkg::AXI_AW-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [cpu_flags_pkg::AXI_AW-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Execution side
    output logic [7:0] o_flags,
    output logic [15:0] o_pc,
    output logic [7:0] o_working_bank_pointer,
    output logic o_watchdog_refresh_op,
    output logic o_busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic [AXI_AW-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        seq_state_t seq;
        logic [7:0] ops_flags;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] result;
        logic wrote;
        logic [8:0] last_op;
        logic unsupported;
        logic [STACK_AW-1:0] sp;
        logic [15:0] pc;
        logic [15:0] vector_pc;
        logic [7:0] bank_ptr;
        logic wdog;
        logic busy;
    } state_t;

    localparam state_t STATE_RESET = '{
        awready: 1'b1, wready: 1'b1, aw_have: 1'b0, awaddr: '0, w_have: 1'b0,
        wdata: '0, wstrb: '0, bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b1,
        rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY, seq: SEQ_IDLE,
        ops_flags: FLAGS_RESET, dst: '0, src: '0, result: '0, wrote: 1'b0,
        last_op: '0, unsupported: 1'b0, sp: '0, pc: PC_RESET, vector_pc: PC_RESET,
        bank_ptr: '0, wdog: 1'b0, busy: 1'b0
    };

    state_t r;
    state_t n;
    logic [1:0] user_reg;
    logic [1:0] user_next;
    logic mem_we;
    logic [STACK_AW-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [31:0] wmerged;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [7:0] flags_now;
    alu_out_t alu;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte-lane merge of a write onto the current contents
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // One ALU step; user bits of the incoming flags pass through untouched
    function automatic alu_out_t alu_step(input logic [8:0] op, input logic [7:0] d,
                                          input logic [7:0] s, input logic [7:0] f);
        alu_out_t o;
        logic [8:0] diff;
        o.known = 1'b1;
        o.store = 1'b0;
        o.res = d;
        o.flags = f;
        diff = {1'b0, d} - {1'b0, s};
        if (op[OP_MAP2_BIT]) begin
            if (op[7:0] == OPC_SHIFT_R || op[7:0] == OPC_SHIFT_IR) begin
                o.res = {1'b0, d[7:1]};
                o.store = 1'b1;
                o.flags[FLAG_C] = d[0];
                o.flags[FLAG_S] = 1'b0;
                // Overflow taken as sign xor carry of the result
                o.flags[FLAG_V] = d[0];
                o.flags[FLAG_Z] = (d[7:1] == 7'h00);
            end else begin
                o.known = 1'b0;
            end
        end else if (op[7:0] >= OPC_SUB_LO && op[7:0] <= OPC_SUB_HI) begin
            o.res = diff[7:0];
            o.store = 1'b1;
            o.flags[FLAG_C] = diff[8];
            o.flags[FLAG_Z] = (diff[7:0] == 8'h00);
            o.flags[FLAG_S] = diff[7];
            o.flags[FLAG_V] = (d[7] != s[7]) && (diff[7] != d[7]);
            o.flags[FLAG_H] = (d[3:0] < s[3:0]);
            o.flags[FLAG_D] = 1'b1;
        end else if (op[7:0] == OPC_SWAP_R || op[7:0] == OPC_SWAP_IR) begin
            // Carry and overflow are undefined here; they simply hold
            o.res = {d[3:0], d[7:4]};
            o.store = 1'b1;
            o.flags[FLAG_Z] = (d == 8'h00);
            o.flags[FLAG_S] = d[3];
        end else if ((op[7:0] >= OPC_TCM_LO && op[7:0] <= OPC_TCM_HI)
                     || (op[7:0] >= OPC_TM_LO && op[7:0] <= OPC_TM_HI)
                     || (op[7:0] >= OPC_XOR_LO && op[7:0] <= OPC_XOR_HI)) begin
            if (op[7:0] <= OPC_TCM_HI) begin
                o.res = ~d & s;
            end else if (op[7:0] <= OPC_TM_HI) begin
                o.res = d & s;
            end else begin
                o.res = d ^ s;
                o.store = 1'b1;
            end
            o.flags[FLAG_Z] = (o.res == 8'h00);
            o.flags[FLAG_S] = o.res[7];
            o.flags[FLAG_V] = 1'b0;
            if (!o.store) begin
                o.res = d;
            end
        end else begin
            o.known = 1'b0;
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    assign flags_now = {r.ops_flags[FLAG_C:FLAG_H], user_reg};
    assign wmerged = lane_merge(32'h0000_0000, r.wdata, r.wstrb);
    assign alu = alu_step({wmerged[OP_MAP2_BIT], wmerged[7:0]}, r.dst, r.src, r.ops_flags);

    // Read mux over the current state
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (i_araddr)
            ADDR_OP: rd_word[8:0] = r.last_op;
            ADDR_DST: rd_word[7:0] = r.dst;
            ADDR_SRC: rd_word[7:0] = r.src;
            ADDR_RESULT: rd_word[8:0] = {r.wrote, r.result};
            ADDR_FLAGS: rd_word[7:0] = flags_now;
            ADDR_SP: rd_word[STACK_AW-1:0] = r.sp;
            ADDR_PC: rd_word[15:0] = r.pc;
            ADDR_VECTOR_PC: rd_word[15:0] = r.vector_pc;
            ADDR_EVENT: rd_word = 32'h0000_0000;
            ADDR_STATUS: begin
                rd_word[ST_BUSY] = r.busy;
                rd_word[ST_UNSUPPORTED] = r.unsupported;
                rd_word[ST_BANK_LSB +: 8] = r.bank_ptr;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.wdog = 1'b0;
        user_next = user_reg;
        mem_we = 1'b0;
        mem_addr = r.sp;
        mem_wdata = 8'h00;

        // Address and data channels are captured independently
        if (r.awready && i_awvalid) begin
            n.aw_have = 1'b1;
            n.awaddr = i_awaddr;
        end
        if (r.wready && i_wvalid) begin
            n.w_have = 1'b1;
            n.wdata = i_wdata;
            n.wstrb = i_wstrb;
        end
        if (r.bvalid && i_bready) begin
            n.bvalid = 1'b0;
        end

        // Perform a write once both halves are held and no response waits
        if (r.aw_have && r.w_have && !r.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (r.awaddr)
                ADDR_OP: begin
                    // Ops are dropped while the stack sequencer runs
                    if (!r.busy && r.wstrb[0]) begin
                        n.last_op = {wmerged[OP_MAP2_BIT], wmerged[7:0]};
                        n.unsupported = 1'b0;
                        if (!wmerged[OP_MAP2_BIT] && wmerged[7:0] == OPC_BANK_LOAD) begin
                            n.bank_ptr = r.src;
                        end else if (!wmerged[OP_MAP2_BIT] && wmerged[7:0] == OPC_WDOG) begin
                            n.wdog = 1'b1;
                        end else if (!wmerged[OP_MAP2_BIT] && wmerged[7:0] == OPC_TRAP) begin
                            n.seq = SEQ_PUSH_PC_HI;
                            n.busy = 1'b1;
                        end else if (alu.known) begin
                            n.ops_flags = alu.flags & OPS_FLAG_MASK;
                            n.result = alu.res;
                            n.wrote = alu.store;
                            if (alu.store) begin
                                n.dst = alu.res;
                            end
                        end else begin
                            n.unsupported = 1'b1;
                        end
                    end
                end
                ADDR_DST: n.dst = 8'(lane_merge({24'h0, r.dst}, r.wdata, r.wstrb));
                ADDR_SRC: n.src = wmerged[7:0] | (r.wstrb[0] ? 8'h00 : r.src);
                ADDR_FLAGS: begin
                    if (!r.busy && r.wstrb[0]) begin
                        n.ops_flags = r.wdata[7:0] & OPS_FLAG_MASK;
                        user_next = r.wdata[FLAG_USER2:FLAG_USER1];
                    end
                end
                ADDR_SP: begin
                    if (!r.busy) begin
                        n.sp = STACK_AW'(lane_merge({{(32-STACK_AW){1'b0}}, r.sp}, r.wdata,
                                                    r.wstrb));
                    end
                end
                ADDR_PC: begin
                    if (!r.busy) begin
                        n.pc = 16'(lane_merge({16'h0, r.pc}, r.wdata, r.wstrb));
                    end
                end
                ADDR_VECTOR_PC: n.vector_pc = 16'(lane_merge({16'h0, r.vector_pc}, r.wdata,
                                                             r.wstrb));
                ADDR_EVENT: begin
                    if (!r.busy && r.wstrb[0]) begin
                        if (r.wdata[EV_INTERRUPT] || r.wdata[EV_ILLEGAL]) begin
                            n.seq = SEQ_PUSH_PC_HI;
                            n.busy = 1'b1;
                        end else if (r.wdata[EV_INTERRUPT_RETURN_OP]) begin
                            n.seq = SEQ_POP_FLAGS;
                            n.busy = 1'b1;
                        end
                    end
                end
                ADDR_RESULT, ADDR_STATUS: begin
                end
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have;
        n.wready = !n.w_have;

        // Read channel: one outstanding read, answered the cycle after
        if (r.rvalid && i_rready) begin
            n.rvalid = 1'b0;
        end
        if (r.arready && i_arvalid) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word;
            n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        n.arready = !n.rvalid;

        // Stack sequencer; flags never change on the push path
        case (r.seq)
            SEQ_IDLE: begin
            end
            SEQ_PUSH_PC_HI: begin
                mem_we = 1'b1;
                mem_addr = STACK_AW'(r.sp - STACK_AW'(2));
                mem_wdata = r.pc[15:8];
                n.sp = STACK_AW'(r.sp - STACK_AW'(2));
                n.seq = SEQ_PUSH_PC_LO;
            end
            SEQ_PUSH_PC_LO: begin
                mem_we = 1'b1;
                mem_addr = STACK_AW'(r.sp + STACK_AW'(1));
                mem_wdata = r.pc[7:0];
                n.seq = SEQ_PUSH_FLAGS;
            end
            SEQ_PUSH_FLAGS: begin
                mem_we = 1'b1;
                mem_addr = STACK_AW'(r.sp - STACK_AW'(1));
                mem_wdata = flags_now;
                n.sp = STACK_AW'(r.sp - STACK_AW'(1));
                n.pc = r.vector_pc;
                n.seq = SEQ_IDLE;
                n.busy = 1'b0;
            end
            SEQ_POP_FLAGS: begin
                mem_addr = r.sp;
                n.seq = SEQ_POP_PC_HI;
            end
            SEQ_POP_PC_HI: begin
                mem_addr = STACK_AW'(r.sp + STACK_AW'(1));
                n.ops_flags = mem_rdata & OPS_FLAG_MASK;
                user_next = mem_rdata[FLAG_USER2:FLAG_USER1];
                n.seq = SEQ_POP_PC_LO;
            end
            SEQ_POP_PC_LO: begin
                mem_addr = STACK_AW'(r.sp + STACK_AW'(2));
                n.pc[15:8] = mem_rdata;
                n.seq = SEQ_POP_DONE;
            end
            SEQ_POP_DONE: begin
                n.pc[7:0] = mem_rdata;
                n.sp = STACK_AW'(r.sp + STACK_AW'(3));
                n.seq = SEQ_IDLE;
                n.busy = 1'b0;
            end
            default: begin
                n.seq = SEQ_IDLE;
                n.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= STATE_RESET;
        end else if (i_ce) begin
            r <= n;
        end
    end

    // User bits carry no reset so a reset leaves them as they were
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            user_reg <= user_next;
        end
    end

    // ------------------------------------------------------------
    // Stack memory
    // ------------------------------------------------------------
    stack_ram #(
        .AW(STACK_AW),
        .DW(8)
    ) u_stack (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign o_awready = r.awready;
    assign o_wready = r.wready;
    assign o_bvalid = r.bvalid;
    assign o_bresp = r.bresp;
    assign o_arready = r.arready;
    assign o_rvalid = r.rvalid;
    assign o_rdata = r.rdata;
    assign o_rresp = r.rresp;
    // Jump conditions use C V Z S only; D H and user bits are for readers
    assign o_flags = flags_now;
    assign o_pc = r.pc;
    assign o_working_bank_pointer = r.bank_ptr;
    assign o_watchdog_refresh_op = r.wdog;
    assign o_busy = r.busy;

endmodule

// ### sim/cpu_flags_alu_checker.sv
// Handshake and flag update assertions for the flags and ALU block
`timescale 1ns/1ps

module cpu_flags_alu_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bus handshakes
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic o_arready,
    // Execution side
    input wire logic o_busy,
    input wire logic o_watchdog_refresh_op,
    input wire logic [7:0] o_flags
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Answers stand until taken, then drop
    chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    chk_bvalid_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write response not cleared");
    chk_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
        else $error("read answer dropped early");
    chk_ar_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("read address open while answer pending");
    // Stack sequence starts with an accepted write and runs 3 or 4 cycles
    chk_busy_cause: assert property ($rose(o_busy) |-> o_bvalid)
        else $error("stack sequence without a write");
    chk_busy_len: assert property ($rose(o_busy) |-> o_busy[*3] ##[1:2] !o_busy)
        else $error("stack sequence length wrong");
    // Flags move only on a performed write or during a pop
    chk_flags_cause: assert property ($changed(o_flags) |-> $rose(o_bvalid) || $past(o_busy))
        else $error("flags changed without cause");
    chk_wdog_pulse: assert property (o_watchdog_refresh_op |=> !o_watchdog_refresh_op)
        else $error("refresh pulse longer than one cycle");

    cover property ($rose(o_busy));
    cover property (o_watchdog_refresh_op);
    cover property ($changed(o_flags[1:0]));
endmodule

bind cpu_flags_alu cpu_flags_alu_checker i_chk (.i_clk, .i_rst, .o_bvalid, .i_bready,
    .o_rvalid, .i_rready, .o_arready, .o_busy, .o_watchdog_refresh_op, .o_flags);

// ### sim/tb.sv
// Self-checking bench for the flags and ALU block
`timescale 1ns/1ps

module tb;
    import cpu_flags_pkg::*;
    // ----------------------------------------
    // Signals, clock, design
    // ----------------------------------------
    logic i_clk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_awvalid = 1'h0, i_wvalid = 1'h0;
    logic i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0, o_awready, o_wready;
    logic o_bvalid, o_arready, o_rvalid, o_watchdog_refresh_op, o_busy;
    logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
    logic [3:0] i_wstrb = 4'hF;
    logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0, o_flags, o_working_bank_pointer;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    logic [1:0] o_bresp, o_rresp, rr;
    logic [15:0] o_pc;
    int failures = 0, n_checks = 0, n_wd = 0;
    always #50 i_clk = ~i_clk;
    // Count refresh pulses
    always @(posedge i_clk) if (o_watchdog_refresh_op === 1'h1) n_wd++;
    cpu_flags_alu i_dut (.*);

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bounded wait step, sampled mid-cycle where registered outputs are settled
    task automatic tick(inout int n);
        @(negedge i_clk);
        n++;
        if (n > 300) begin
            failures++;
            end_sim;
        end
    endtask
    // One bus transfer; each valid is held until its own ready edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic ta, tw, tr, tk;
        @(posedge i_clk);
        i_awaddr <= a;
        i_araddr <= a;
        i_wdata <= d;
        i_awvalid <= w;
        i_wvalid <= w;
        i_bready <= w;
        i_arvalid <= !w;
        i_rready <= !w;
        do begin
            tick(n);
            ta = o_awready & i_awvalid;
            tw = o_wready & i_wvalid;
            tr = o_arready & i_arvalid;
            tk = w ? o_bvalid : o_rvalid;
            rr = w ? o_bresp : o_rresp;
            rv = o_rdata;
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'h0;
            if (tw) i_wvalid <= 1'h0;
            if (tr) i_arvalid <= 1'h0;
        end while (tk !== 1'h1);
        i_bready <= 1'h0;
        i_rready <= 1'h0;
    endtask
    task automatic rst;
        i_rst <= 1'h1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'h0;
    endtask
    // Op, flag, SP, PC and event writes are ignored while the stack sequence runs, so wait it out
    task automatic idle;
        int n = 0;
        do tick(n);
        while (o_busy !== 1'h0);
    endtask

    task automatic t_user;
        bus(1'h1, ADDR_FLAGS, 32'hFF);
        rst;
        bus(1'h0, ADDR_FLAGS, 32'h0);
        chk(rv, 32'h3);
        chk(32'(o_pc), 32'(PC_RESET));
        $display("reset test done");
    endtask
    // Rows: opcode, dst, src, flags, {stored, result}; flags chain from row to row
    task automatic t_alu;
        logic [47:0] tbl [11] = '{48'h022_1021_AF_1EF, 48'h062_F00F_8F_0F0,
            48'h072_F00F_CF_0F0, 48'h0B2_F00F_AF_1FF, 48'h1C0_8100_9F_140,
            48'h0F0_5A00_BF_1A5, 48'h029_0001_AF_1FF, 48'h069_0F0F_CF_00F,
            48'h0B9_0F0F_CF_100, 48'h1C1_0100_DF_100, 48'h022_8001_1F_17F};
        foreach (tbl[i]) begin
            bus(1'h1, ADDR_DST, 32'(tbl[i][35:28]));
            bus(1'h1, ADDR_SRC, 32'(tbl[i][27:20]));
            bus(1'h1, ADDR_OP, 32'(tbl[i][44:36]));
            bus(1'h0, ADDR_FLAGS, 32'h0);
            chk(rv, 32'(tbl[i][19:12]));
            chk(32'(o_flags), 32'(tbl[i][19:12]));
            bus(1'h0, ADDR_RESULT, 32'h0);
            chk(rv, 32'(tbl[i][8:0]));
        end
        $display("alu test done");
    endtask
    // Vector call, interrupt entry, illegal trap; each undone by a return
    task automatic t_stack;
        for (int i = 0; i < 3; i++) begin
            bus(1'h1, ADDR_SP, 32'h80);
            bus(1'h1, ADDR_PC, 32'h1234);
            bus(1'h1, ADDR_VECTOR_PC, 32'hBEEF);
            bus(1'h1, i == 0 ? ADDR_OP : ADDR_EVENT, i == 0 ? 32'hF2 : 32'(i));
            idle;
            chk(32'(o_pc), 32'hBEEF);
            bus(1'h0, ADDR_SP, 32'h0);
            chk(rv, 32'h7D);
            chk(32'(o_flags), 32'h1F);
            bus(1'h1, ADDR_FLAGS, 32'h2);
            bus(1'h1, ADDR_EVENT, 32'h4);
            idle;
            chk(32'(o_flags), 32'h1F);
            chk(32'(o_pc), 32'h1234);
        end
        $display("stack test done");
    endtask
    task automatic t_misc;
        bus(1'h1, ADDR_SRC, 32'h5A);
        bus(1'h1, ADDR_OP, 32'h01);
        bus(1'h0, ADDR_STATUS, 32'h0);
        chk(32'(rv[15:8]), 32'h5A);
        chk(32'(o_working_bank_pointer), 32'h5A);
        bus(1'h1, ADDR_OP, 32'h5F);
        idle;
        chk(32'(n_wd), 32'h1);
        // Unknown second-map opcode raises the unsupported bit and is still latched as the last op
        bus(1'h1, ADDR_OP, 32'h1FF);
        bus(1'h0, ADDR_STATUS, 32'h0);
        chk(rv, 32'h5A02);
        bus(1'h0, ADDR_OP, 32'h0);
        chk(rv, 32'h1FF);
        bus(1'h0, 8'h40, 32'h0);
        chk(rv, 32'h0);
        chk(32'(rr), 32'(RESP_SLVERR));
        bus(1'h1, 8'h40, 32'h1);
        chk(32'(rr), 32'(RESP_SLVERR));
        chk(32'(o_flags), 32'h1F);
        $display("misc test done");
    endtask

    initial begin
        rst;
        t_user;
        t_alu;
        t_stack;
        t_misc;
        end_sim;
    end
endmodule
